// ==== design/nand_host.sv ====
// host sequencer for a page-organised flash on a shared 8-bit bus
// assumes flash pins synchronous to i_core_clk, ready/busy pulled up
`timescale 1ns/1ns
`default_nettype none
module nand_host #(
   parameter int LEN_W = nand_host_pkg::LEN_W
) (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_req_valid,
   input wire nand_host_pkg::op_t i_op,
   input wire logic [nand_host_pkg::ADDR_W-1:0] i_addr,
   input wire logic [LEN_W-1:0] i_len,
   input wire logic i_write_protect,
   input wire logic i_wvalid,
   input wire logic [7:0] i_wdata,
   output logic o_req_ack,
   output logic o_idle,
   output logic o_wready,
   output logic o_rvalid,
   output logic [7:0] o_rdata,
   output logic o_done,
   output logic o_cle,
   output logic o_ale,
   output logic o_ce_n,
   output logic o_we_n,
   output logic o_read_strobe_n,
   output logic o_spare_area_select_n,
   output logic o_wp_n,
   input wire logic [7:0] i_shared_io_bus,
   output logic [7:0] o_shared_io_bus,
   output logic o_shared_io_bus_oe,
   input wire logic i_ready_busy_n
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_ADDR = 3'b011,
      ST_WDATA = 3'b010,
      ST_CMD2 = 3'b110,
      ST_SETTLE = 3'b111,
      ST_WAIT_RB = 3'b101,
      ST_RDATA = 3'b100
   } st_t;

   localparam logic [2:0] SETTLE_LAST =
      3'(nand_host_pkg::BUSY_SETTLE_CYC - 1);

   nand_cycle_if cyc ();

   st_t st_q;
   nand_host_pkg::op_t op_q;
   logic [nand_host_pkg::ADDR_W-1:0] addr_q;
   logic [LEN_W-1:0] left_q;
   logic [1:0] aidx_q;
   logic [1:0] alast_q;
   logic [2:0] wait_q;
   logic act_q;
   logic allowed;
   logic take;
   logic step;

   // other commands held back while device is busy
   always_comb begin
      allowed = i_ready_busy_n || i_op == nand_host_pkg::OP_RESET ||
                i_op == nand_host_pkg::OP_SUSPEND ||
                i_op == nand_host_pkg::OP_STATUS;
      if (i_write_protect && (i_op == nand_host_pkg::OP_PROGRAM ||
          i_op == nand_host_pkg::OP_ERASE)) begin
         allowed = 1'b0;
      end
   end

   assign take = o_idle && i_req_valid && allowed;
   assign step = act_q && cyc.done;

   function automatic logic [7:0] first_cmd(input nand_host_pkg::op_t op,
                                            input logic half);
      unique case (op)
         nand_host_pkg::OP_READ:
            first_cmd = half ? nand_host_pkg::CMD_READ_HALF1
                             : nand_host_pkg::CMD_READ_HALF0;
         nand_host_pkg::OP_READ_SPARE: first_cmd = nand_host_pkg::CMD_READ_SPARE;
         nand_host_pkg::OP_READ_ID: first_cmd = nand_host_pkg::CMD_READ_ID;
         nand_host_pkg::OP_STATUS: first_cmd = nand_host_pkg::CMD_STATUS;
         nand_host_pkg::OP_PROGRAM: first_cmd = nand_host_pkg::CMD_DATA_IN;
         nand_host_pkg::OP_ERASE: first_cmd = nand_host_pkg::CMD_ERASE_SETUP;
         nand_host_pkg::OP_SUSPEND: first_cmd = nand_host_pkg::CMD_SUSPEND;
         nand_host_pkg::OP_RESUME: first_cmd = nand_host_pkg::CMD_RESUME;
         default: first_cmd = nand_host_pkg::CMD_RESET;
      endcase
   endfunction

   function automatic logic [7:0] addr_byte(input logic [1:0] idx,
         input logic [nand_host_pkg::ADDR_W-1:0] a);
      unique case (idx)
         2'd0: addr_byte = a[7:0];
         2'd1: addr_byte = a[nand_host_pkg::ROW_LO_BIT +: 8];
         default: addr_byte = {3'b000,
            a[nand_host_pkg::ROW_HI_BIT +: nand_host_pkg::ROW_HI_W]};
      endcase
   endfunction

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q <= ST_IDLE;
         op_q <= nand_host_pkg::OP_RESET;
         addr_q <= '0;
         left_q <= '0;
         aidx_q <= '0;
         alast_q <= '0;
         wait_q <= '0;
      end else begin
         unique case (st_q)
            ST_IDLE: if (take) begin
               st_q <= ST_CMD;
               op_q <= i_op;
               addr_q <= (i_op == nand_host_pkg::OP_READ_ID) ? '0 : i_addr;
               left_q <= i_len;
               aidx_q <= (i_op == nand_host_pkg::OP_ERASE) ? 2'd1 : 2'd0;
               alast_q <= (i_op == nand_host_pkg::OP_READ_ID) ? 2'd0 : 2'd2;
            end
            ST_CMD: if (step) begin
               unique case (op_q)
                  nand_host_pkg::OP_READ, nand_host_pkg::OP_READ_SPARE,
                  nand_host_pkg::OP_READ_ID, nand_host_pkg::OP_PROGRAM,
                  nand_host_pkg::OP_ERASE: st_q <= ST_ADDR;
                  nand_host_pkg::OP_STATUS: st_q <= ST_RDATA;
                  default: st_q <= ST_SETTLE;
               endcase
            end
            ST_ADDR: if (step) begin
               aidx_q <= aidx_q + 2'd1;
               if (aidx_q == alast_q) begin
                  unique case (op_q)
                     nand_host_pkg::OP_PROGRAM:
                        st_q <= (left_q == '0) ? ST_CMD2 : ST_WDATA;
                     nand_host_pkg::OP_ERASE: st_q <= ST_CMD2;
                     nand_host_pkg::OP_READ_ID: st_q <= ST_RDATA;
                     default: st_q <= ST_SETTLE; // random read busy
                  endcase
               end
            end
            ST_WDATA: if (step) begin
               left_q <= left_q - 1'b1;
               if (left_q == LEN_W'(1)) st_q <= ST_CMD2;
            end
            ST_CMD2: if (step) st_q <= ST_SETTLE;
            ST_SETTLE: begin
               wait_q <= wait_q + 3'd1;
               if (wait_q == SETTLE_LAST) begin
                  wait_q <= '0;
                  st_q <= ST_WAIT_RB;
               end
            end
            ST_WAIT_RB: if (i_ready_busy_n) begin
               st_q <= (op_q == nand_host_pkg::OP_READ ||
                        op_q == nand_host_pkg::OP_READ_SPARE) &&
                       left_q != '0 ? ST_RDATA : ST_IDLE;
            end
            ST_RDATA: if (step) begin
               left_q <= left_q - 1'b1;
               if (left_q <= LEN_W'(1)) st_q <= ST_IDLE;
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   // issue one bus cycle per step; data waits for a write byte
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         act_q <= 1'b0;
         cyc.start <= 1'b0;
         cyc.kind <= nand_host_pkg::CYC_CMD;
         cyc.wbyte <= '0;
         o_wready <= 1'b0;
      end else begin
         cyc.start <= 1'b0;
         o_wready <= 1'b0;
         if (step) begin
            act_q <= 1'b0;
         end else if (!act_q && !cyc.start) begin
            unique case (st_q)
               ST_CMD: begin
                  act_q <= 1'b1;
                  cyc.start <= 1'b1;
                  cyc.kind <= nand_host_pkg::CYC_CMD;
                  cyc.wbyte <= first_cmd(op_q, addr_q[nand_host_pkg::HALF_BIT]);
               end
               ST_ADDR: begin
                  act_q <= 1'b1;
                  cyc.start <= 1'b1;
                  cyc.kind <= nand_host_pkg::CYC_ADDR;
                  cyc.wbyte <= addr_byte(aidx_q, addr_q);
               end
               ST_WDATA: if (i_wvalid) begin
                  act_q <= 1'b1;
                  cyc.start <= 1'b1;
                  o_wready <= 1'b1;
                  cyc.kind <= nand_host_pkg::CYC_WDATA;
                  cyc.wbyte <= i_wdata;
               end
               ST_CMD2: begin
                  act_q <= 1'b1;
                  cyc.start <= 1'b1;
                  cyc.kind <= nand_host_pkg::CYC_CMD;
                  cyc.wbyte <= (op_q == nand_host_pkg::OP_ERASE) ?
                     nand_host_pkg::CMD_ERASE_GO : nand_host_pkg::CMD_PROGRAM;
               end
               ST_RDATA: begin
                  act_q <= 1'b1;
                  cyc.start <= 1'b1;
                  cyc.kind <= nand_host_pkg::CYC_RDATA;
               end
               default: act_q <= 1'b0;
            endcase
         end
      end
   end

   // user-side answers and chip-level pins
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_req_ack <= 1'b0;
         o_idle <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= '0;
         o_done <= 1'b0;
         o_ce_n <= 1'b1;
         o_spare_area_select_n <= 1'b1;
         o_wp_n <= 1'b0;
      end else begin
         o_req_ack <= take;
         o_idle <= (st_q == ST_IDLE) && !take && !o_req_ack;
         o_rvalid <= step && st_q == ST_RDATA;
         if (step && st_q == ST_RDATA) o_rdata <= cyc.rbyte;
         o_done <= st_q != ST_IDLE && st_q != ST_CMD && (
            (st_q == ST_WAIT_RB && i_ready_busy_n &&
             !((op_q == nand_host_pkg::OP_READ ||
                op_q == nand_host_pkg::OP_READ_SPARE) && left_q != '0)) ||
            (st_q == ST_RDATA && step && left_q <= LEN_W'(1)));
         o_wp_n <= !i_write_protect;
         if (take) begin
            o_ce_n <= 1'b0;
            o_spare_area_select_n <=
               (i_op != nand_host_pkg::OP_READ_SPARE);
         end else if (st_q == ST_IDLE && !o_req_ack) begin
            o_ce_n <= 1'b1;
            o_spare_area_select_n <= 1'b1;
         end
      end
   end

   nand_strobe_engine u_eng (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .cyc(cyc.eng),
      .i_bus(i_shared_io_bus),
      .o_cle(o_cle),
      .o_ale(o_ale),
      .o_we_n(o_we_n),
      .o_read_strobe_n(o_read_strobe_n),
      .o_bus(o_shared_io_bus),
      .o_bus_oe(o_shared_io_bus_oe)
   );
endmodule
`default_nettype wire

// ==== design/nand_strobe_engine.sv ====
// strobe engine: runs one write or read bus cycle on the flash pins
// assumes start only while idle; pins synchronous to i_core_clk
`timescale 1ns/1ns
`default_nettype none
module nand_strobe_engine (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   nand_cycle_if.eng cyc,
   input wire logic [7:0] i_bus,
   output logic o_cle,
   output logic o_ale,
   output logic o_we_n,
   output logic o_read_strobe_n,
   output logic [7:0] o_bus,
   output logic o_bus_oe
);
   typedef enum logic [1:0] {
      SE_IDLE = 2'b00,
      SE_LOW = 2'b01,
      SE_HIGH = 2'b11
   } eng_st_t;

   localparam int CW = 3;
   localparam logic [CW-1:0] LOW_LAST =
      CW'(nand_host_pkg::STROBE_LOW_CYC - 1);
   localparam logic [CW-1:0] HIGH_LAST =
      CW'(nand_host_pkg::STROBE_HIGH_CYC - 1);

   eng_st_t st_q;
   logic [CW-1:0] cnt_q;
   logic rd_q;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_q <= SE_IDLE;
         cnt_q <= '0;
         rd_q <= 1'b0;
      end else begin
         unique case (st_q)
            SE_IDLE: begin
               cnt_q <= '0;
               if (cyc.start) begin
                  st_q <= SE_LOW;
                  rd_q <= (cyc.kind == nand_host_pkg::CYC_RDATA);
               end
            end
            SE_LOW: begin
               cnt_q <= (cnt_q == LOW_LAST) ? '0 : cnt_q + 1'b1;
               if (cnt_q == LOW_LAST) st_q <= SE_HIGH;
            end
            SE_HIGH: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == HIGH_LAST) st_q <= SE_IDLE;
            end
            default: st_q <= SE_IDLE;
         endcase
      end
   end

   // strobes: write byte latched by device on we_n rise
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_we_n <= 1'b1;
         o_read_strobe_n <= 1'b1;
      end else begin
         if (st_q == SE_IDLE && cyc.start) begin
            o_we_n <= (cyc.kind == nand_host_pkg::CYC_RDATA);
            o_read_strobe_n <= (cyc.kind != nand_host_pkg::CYC_RDATA);
         end else if (st_q == SE_LOW && cnt_q == LOW_LAST) begin
            o_we_n <= 1'b1;
            o_read_strobe_n <= 1'b1;
         end
      end
   end

   // latch enables and bus drive held through the whole cycle
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_cle <= 1'b0;
         o_ale <= 1'b0;
         o_bus <= '0;
         o_bus_oe <= 1'b0;
      end else if (st_q == SE_IDLE && cyc.start) begin
         o_cle <= (cyc.kind == nand_host_pkg::CYC_CMD);
         o_ale <= (cyc.kind == nand_host_pkg::CYC_ADDR);
         o_bus <= cyc.wbyte;
         o_bus_oe <= (cyc.kind != nand_host_pkg::CYC_RDATA);
      end else if (st_q == SE_HIGH && cnt_q == HIGH_LAST) begin
         o_cle <= 1'b0;
         o_ale <= 1'b0;
         o_bus_oe <= 1'b0;
      end
   end

   // sample read byte at end of low phase, answer at cycle end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cyc.rbyte <= '0;
         cyc.done <= 1'b0;
      end else begin
         if (st_q == SE_LOW && cnt_q == LOW_LAST && rd_q) cyc.rbyte <= i_bus;
         cyc.done <= (st_q == SE_HIGH && cnt_q == HIGH_LAST);
      end
   end
endmodule
`default_nettype wire

// ==== inc/nand_cycle_if.sv ====
// one bus cycle request and answer between sequencer and strobe engine
// assumes both ends on the same core clock
`timescale 1ns/1ns
`default_nettype none
interface nand_cycle_if;
   logic start;
   nand_host_pkg::cyc_kind_t kind;
   logic [7:0] wbyte;
   logic done;
   logic [7:0] rbyte;

   modport seq (output start, output kind, output wbyte,
                input done, input rbyte);
   modport eng (input start, input kind, input wbyte,
                output done, output rbyte);
endinterface
`default_nettype wire

// ==== inc/nand_host_pkg.sv ====
// constants for the page-flash host controller
// assumes a 50 MHz core clock and pins synchronous to it
package nand_host_pkg;

   localparam int CLK_PERIOD_NS = 20;

   // strobe low and high phases, least times, rounded up
   localparam int T_STROBE_LOW_NS = 30;
   localparam int T_STROBE_HIGH_NS = 30;
   // wait before ready/busy is trusted, least time
   localparam int T_BUSY_SETTLE_NS = 100;

   localparam int STROBE_LOW_CYC =
      (T_STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_HIGH_CYC =
      (T_STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_SETTLE_CYC =
      (T_BUSY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam int BUS_W = 8;
   localparam int ADDR_W = 22;
   localparam int LEN_W = 10;
   localparam int PAGE_BYTES = 528;
   localparam int SPARE_FIRST_COL = 512;
   localparam int SPARE_LAST_COL = 527;
   localparam int PAGE_COUNT = 8192;
   localparam int BLOCK_PAGES = 16;
   localparam int BLOCK_COUNT = 512;

   // address field positions
   localparam int HALF_BIT = 8;
   localparam int ROW_LO_BIT = 9;
   localparam int ROW_HI_BIT = 17;
   localparam int ROW_HI_W = 5;

   localparam logic [7:0] CMD_DATA_IN = 8'h80;
   localparam logic [7:0] CMD_READ_HALF0 = 8'h00;
   localparam logic [7:0] CMD_READ_HALF1 = 8'h01;
   localparam logic [7:0] CMD_READ_SPARE = 8'h50;
   localparam logic [7:0] CMD_READ_ID = 8'h90;
   localparam logic [7:0] CMD_RESET = 8'hFF;
   localparam logic [7:0] CMD_PROGRAM = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_RESUME = 8'hD0;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] ID_ADDR_BYTE = 8'h00;

   typedef enum logic [3:0] {
      OP_READ = 4'h0,
      OP_READ_SPARE = 4'h1,
      OP_READ_ID = 4'h2,
      OP_STATUS = 4'h3,
      OP_PROGRAM = 4'h4,
      OP_ERASE = 4'h5,
      OP_RESET = 4'h6,
      OP_SUSPEND = 4'h7,
      OP_RESUME = 4'h8
   } op_t;

   typedef enum logic [1:0] {
      CYC_CMD = 2'h0,
      CYC_ADDR = 2'h1,
      CYC_WDATA = 2'h2,
      CYC_RDATA = 2'h3
   } cyc_kind_t;

endpackage

// ==== test/flash_device_model.sv ====
// behavioural page flash on the host pins, data from a fixed pattern
// assumes pins change in step with the clock; i_hold_busy stretches busy
`timescale 1ns/1ns
`default_nettype none
module flash_device_model #(
   parameter int BUSY_CYC = 20,
   parameter logic [15:0] ID_PAIR = 16'h5AC3 // arbitrary codes
) (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_cle,
   input wire logic i_ale,
   input wire logic i_ce_n,
   input wire logic i_we_n,
   input wire logic i_read_strobe_n,
   input wire logic i_spare_area_select_n,
   input wire logic i_wp_n,
   input wire logic i_hold_busy,
   input wire logic [7:0] i_io,
   output logic [7:0] o_io,
   output logic o_ready_busy_n,
   output logic [7:0] o_last_cmd,
   output logic [23:0] o_addr,
   output logic [1:0] o_naddr,
   output logic [15:0] o_dsum,
   output logic [7:0] o_dcount
);
   logic we_q, rs_q, drive_q, busy;
   logic [7:0] last_q, rd_byte;
   logic [9:0] col_q;
   logic [15:0] busy_q;
   logic [12:0] row;
   assign busy = busy_q != 16'h0000 || i_hold_busy;
   assign o_ready_busy_n = !busy;
   assign row = {o_addr[4:0], o_addr[15:8]};
   // released bus shows the inverse of the last byte
   assign o_io = drive_q ? last_q : ~last_q;
   always_comb begin
      case (o_last_cmd)
         8'h70: rd_byte = {i_wp_n, !busy, 6'h00};
         8'h90: rd_byte = col_q[0] ? ID_PAIR[7:0] : ID_PAIR[15:8];
         default: rd_byte = col_q[7:0] ^ {col_q[9:8], 6'h00} ^ row[7:0];
      endcase
   end
   always @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         {we_q, rs_q, drive_q} <= 3'h6;
         {last_q, col_q, busy_q, o_last_cmd} <= 42'h0;
         {o_addr, o_naddr, o_dsum, o_dcount} <= 50'h0;
      end else begin
         we_q <= i_we_n;
         rs_q <= i_read_strobe_n;
         if (busy_q != 16'h0000)
            busy_q <= busy_q - 16'h0001;
         if (i_we_n && !we_q && !i_ce_n) begin
            if (i_cle) begin
               if ((!busy || i_io inside {8'hFF, 8'hB0, 8'h70})
                  && !(i_io == 8'h50 && i_spare_area_select_n)) begin
                  o_last_cmd <= i_io;
                  if (!(i_io inside {8'h10, 8'hD0}))
                     o_naddr <= 2'h0;
                  if (i_io == 8'h80)
                     {o_dsum, o_dcount} <= 24'h0;
                  if (i_io inside {8'hFF, 8'hB0}
                     || i_io inside {8'h10, 8'hD0} && i_wp_n)
                     busy_q <= 16'(BUSY_CYC);
               end
            end else if (i_ale) begin
               o_addr <= {o_addr[15:0], i_io};
               o_naddr <= o_naddr + 2'h1;
               // second half only right after 01h
               if (o_naddr == 2'h0)
                  col_q <= (o_last_cmd == 8'h50) ? {6'h20, i_io[3:0]}
                     : {1'b0, o_last_cmd == 8'h01, i_io};
               if (o_naddr == 2'h2 && o_last_cmd inside {8'h00, 8'h01, 8'h50})
                  busy_q <= 16'(BUSY_CYC);
            end else begin
               o_dsum <= o_dsum + {8'h00, i_io};
               o_dcount <= o_dcount + 8'h01;
            end
         end
         if (!i_read_strobe_n && rs_q) begin
            drive_q <= 1'b1;
            last_q <= rd_byte;
            col_q <= col_q + 10'h001;
         end else if (i_read_strobe_n || i_ce_n)
            drive_q <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== test/nand_host_properties.sv ====
// checker for the flash host pins and its request handshake
// assumes binding onto nand_host, single core clock domain
`timescale 1ns/1ns
`default_nettype none
module nand_host_properties (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_req_valid,
   input wire nand_host_pkg::op_t i_op,
   input wire logic i_write_protect,
   input wire logic i_ready_busy_n,
   input wire logic o_req_ack,
   input wire logic o_idle,
   input wire logic o_cle,
   input wire logic o_ale,
   input wire logic o_ce_n,
   input wire logic o_we_n,
   input wire logic o_read_strobe_n,
   input wire logic o_spare_area_select_n,
   input wire logic o_wp_n,
   input wire logic [7:0] o_shared_io_bus,
   input wire logic o_shared_io_bus_oe
);
   logic free_op, guard_op, taken;
   assign free_op = i_op == nand_host_pkg::OP_RESET
      || i_op == nand_host_pkg::OP_SUSPEND || i_op == nand_host_pkg::OP_STATUS;
   assign guard_op = i_op == nand_host_pkg::OP_PROGRAM
      || i_op == nand_host_pkg::OP_ERASE;
   assign taken = i_req_valid && o_idle && (i_ready_busy_n || free_op)
      && !(guard_op && i_write_protect);

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);

   sequence write_low;
      (!o_we_n) [*2] ##1 o_we_n;
   endsequence
   sequence spare_cmd;
      !o_we_n && o_cle && o_shared_io_bus == nand_host_pkg::CMD_READ_SPARE;
   endsequence

   req_taken_a: assert property (taken |=> o_req_ack)
      else $error("request not acknowledged");
   busy_refuse_a: assert property (i_req_valid && o_idle && !i_ready_busy_n
      && !free_op |=> !o_req_ack) else $error("request taken while busy");
   protect_refuse_a: assert property (i_req_valid && i_write_protect
      && guard_op |=> !o_req_ack) else $error("protected op taken");
   wp_pin_a: assert property (i_write_protect |=> !o_wp_n)
      else $error("write protect pin not low");
   latch_excl_a: assert property (!(o_cle && o_ale))
      else $error("both latch strobes high");
   write_drive_a: assert property (!o_we_n |-> o_read_strobe_n && !o_ce_n
      && o_shared_io_bus_oe) else $error("write strobe without bus");
   read_release_a: assert property (!o_read_strobe_n |-> !o_ce_n
      && !o_shared_io_bus_oe) else $error("host drives during read");
   write_pulse_a: assert property ($fell(o_we_n) |-> write_low)
      else $error("write strobe low phase wrong");
   latch_hold_a: assert property ($rose(o_we_n) |-> o_shared_io_bus_oe
      && $stable(o_shared_io_bus) && $stable(o_cle) && $stable(o_ale))
      else $error("byte changed at latch edge");
   spare_sel_a: assert property (spare_cmd |-> !o_spare_area_select_n)
      else $error("spare read without spare select");
   ack_select_a: assert property (o_req_ack |-> !o_ce_n)
      else $error("chip not selected at ack");
   busy_free_c: cover property (taken && free_op && !i_ready_busy_n);
endmodule

bind nand_host nand_host_properties chk_u (.i_core_clk, .i_rstn, .i_req_valid,
   .i_op, .i_write_protect, .i_ready_busy_n, .o_req_ack, .o_idle, .o_cle,
   .o_ale, .o_ce_n, .o_we_n, .o_read_strobe_n, .o_spare_area_select_n,
   .o_wp_n, .o_shared_io_bus, .o_shared_io_bus_oe);
`default_nettype wire

// ==== test/test_nand_host.sv ====
// self-checking bench for nand_host against a behavioural flash
// assumes the flash model and the bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
module test_nand_host;
   logic i_core_clk, i_rstn, i_req_valid, i_write_protect, i_wvalid;
   logic hold_busy, o_req_ack, o_idle, o_wready, o_rvalid, o_done;
   logic o_cle, o_ale, o_ce_n, o_we_n, o_read_strobe_n, o_wp_n;
   logic o_spare_area_select_n, o_shared_io_bus_oe, i_ready_busy_n;
   logic [7:0] i_wdata, o_rdata, o_shared_io_bus, dev_io, dev_cmd;
   logic [7:0] i_shared_io_bus, dev_dcount;
   logic [21:0] i_addr, a;
   logic [9:0] i_len;
   logic [23:0] dev_addr, e;
   logic [15:0] dev_dsum, sum;
   logic [1:0] dev_naddr;
   nand_host_pkg::op_t i_op;
   logic [7:0] wbuf [0:3];
   logic [7:0] rq [$];
   int failures, compares, widx;
   assign i_shared_io_bus = o_shared_io_bus_oe ? o_shared_io_bus : dev_io;

   nand_host dut_u (.i_core_clk, .i_rstn, .i_req_valid, .i_op, .i_addr,
      .i_len, .i_write_protect, .i_wvalid, .i_wdata, .o_req_ack, .o_idle,
      .o_wready, .o_rvalid, .o_rdata, .o_done, .o_cle, .o_ale, .o_ce_n,
      .o_we_n, .o_read_strobe_n, .o_spare_area_select_n, .o_wp_n,
      .i_shared_io_bus, .o_shared_io_bus, .o_shared_io_bus_oe,
      .i_ready_busy_n);
   flash_device_model dev_u (.i_core_clk, .i_rstn, .i_cle(o_cle),
      .i_ale(o_ale), .i_ce_n(o_ce_n), .i_we_n(o_we_n),
      .i_read_strobe_n(o_read_strobe_n), .i_wp_n(o_wp_n),
      .i_spare_area_select_n(o_spare_area_select_n), .i_hold_busy(hold_busy),
      .i_io(i_shared_io_bus), .o_io(dev_io), .o_ready_busy_n(i_ready_busy_n),
      .o_last_cmd(dev_cmd), .o_addr(dev_addr), .o_naddr(dev_naddr),
      .o_dsum(dev_dsum), .o_dcount(dev_dcount));

   initial begin
      i_core_clk = 1'b0;
      forever #10 i_core_clk = ~i_core_clk;
   end
   always @(negedge i_core_clk) begin
      i_wvalid <= ($urandom % 4) != 0;
      i_wdata <= wbuf[widx];
      if (o_rvalid === 1'b1)
         rq.push_back(o_rdata);
   end
   always @(posedge i_core_clk)
      if (o_wready === 1'b1)
         widx <= widx + 1;

   function automatic logic [7:0] pat(input logic [9:0] c,
                                      input logic [12:0] r);
      return c[7:0] ^ {c[9:8], 6'h00} ^ r[7:0];
   endfunction
   function automatic logic [23:0] aseq(input logic [21:0] x);
      return {x[7:0], x[16:9], 3'b000, x[21:17]};
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic run(input nand_host_pkg::op_t op, input logic [21:0] x,
                      input logic [9:0] n);
      int k;
      @(negedge i_core_clk);
      {i_op, i_addr, i_len, i_req_valid} = {op, x, n, 1'b1};
      rq.delete();
      for (k = 0; k < 300 && o_req_ack !== 1'b1; k++)
         @(negedge i_core_clk);
      i_req_valid = 1'b0;
      check(k < 300, 1);
      for (k = 0; k < 8000 && o_done !== 1'b1; k++)
         @(negedge i_core_clk);
      @(negedge i_core_clk) check(k < 8000, 1);
   endtask
   task automatic refuse(input nand_host_pkg::op_t op);
      int k;
      @(negedge i_core_clk);
      {i_op, i_req_valid, k} = {op, 1'b1, 32'h0};
      repeat (30) @(negedge i_core_clk) k += (o_req_ack === 1'b1);
      i_req_valid = 1'b0;
      check(k, 0);
   endtask
   task automatic rd(input logic [21:0] x, input logic [9:0] n,
                     input logic sp);
      logic [9:0] c;
      run(sp ? nand_host_pkg::OP_READ_SPARE : nand_host_pkg::OP_READ, x, n);
      check(dev_cmd, sp ? 8'h50 : {7'h00, x[8]});
      check(dev_addr, aseq(x));
      check(rq.size(), n);
      c = sp ? 10'h200 + {6'h00, x[3:0]} : {1'b0, x[8:0]};
      for (int i = 0; i < rq.size(); i++)
         check(rq[i], pat(c + 10'(i), x[21:9]));
   endtask

   initial begin
      {i_rstn, i_req_valid, i_write_protect, hold_busy} = 4'h0;
      {i_addr, i_len, widx} = '0;
      i_op = nand_host_pkg::OP_STATUS;
      void'($urandom(44));
      repeat (5) @(posedge i_core_clk);
      @(negedge i_core_clk) i_rstn = 1'b1;
      run(nand_host_pkg::OP_STATUS, 22'h000000, 10'h001);
      check({dev_cmd, rq[0]}, 16'h70C0);
      run(nand_host_pkg::OP_READ_ID, 22'h000000, 10'h002);
      check({dev_cmd, rq[0], rq[1]}, 24'h905AC3);
      rd(22'h000000, 10'h003, 1'b0);
      rd(22'h3FFFFF, 10'h002, 1'b0);
      rd(22'h2A5100, 10'h000, 1'b0);
      rd(22'h2A5105, 10'h004, 1'b1);
      repeat (6) rd(22'($urandom), 10'(1 + $urandom % 4), 1'b0);
      sum = 16'h0000;
      for (int i = 0; i < 3; i++) begin
         wbuf[i] = 8'($urandom);
         sum += {8'h00, wbuf[i]};
      end
      widx = 0;
      a = 22'($urandom);
      run(nand_host_pkg::OP_PROGRAM, a, 10'h003);
      check({dev_cmd, dev_addr}, {8'h10, aseq(a)});
      check({dev_dcount, dev_dsum}, {8'h03, sum});
      a = 22'($urandom);
      e = aseq(a);
      run(nand_host_pkg::OP_ERASE, a, 10'h000);
      check({dev_cmd, dev_naddr}, {8'hD0, 2'h2});
      check(dev_addr[15:0], e[15:0]);
      i_write_protect = 1'b1;
      refuse(nand_host_pkg::OP_PROGRAM);
      refuse(nand_host_pkg::OP_ERASE);
      i_write_protect = 1'b0;
      hold_busy = 1'b1;
      refuse(nand_host_pkg::OP_READ);
      refuse(nand_host_pkg::OP_PROGRAM);
      run(nand_host_pkg::OP_STATUS, 22'h000000, 10'h001);
      check({dev_cmd, rq[0]}, 16'h7080);
      fork
         run(nand_host_pkg::OP_SUSPEND, 22'h000000, 10'h000);
         #800 hold_busy = 1'b0;
      join
      check(dev_cmd, 8'hB0);
      hold_busy = 1'b1;
      fork
         run(nand_host_pkg::OP_RESET, 22'h000000, 10'h000);
         #800 hold_busy = 1'b0;
      join
      check(dev_cmd, 8'hFF);
      run(nand_host_pkg::OP_RESUME, 22'h000000, 10'h000);
      check(dev_cmd, 8'hD0);
      finish_test();
   end
   initial begin
      repeat (60000) @(posedge i_core_clk);
      failures++;
      finish_test();
   end
endmodule
`default_nettype wire
